// [shared/dpm_pkg.sv]
// Constants, carriers and states for the dual-port pixel input map.
// Shared by the core top, the per-port deserialiser and the bench.
// Functional notes
// [RULE1] Strap open selects map A; strap held low selects map B.
// [RULE2] Strap pulled up inside the device, so an open strap reads high: map A.
// [RULE3] Odd pixels arrive on four odd lanes with their own forwarded clock.
// [RULE4] Even pixels arrive on four even lanes with their own forwarded clock.
// [RULE5] Map A lane 0: red bits 0-5 in slots 0-5, green bit 0 in slot 6.
// [RULE6] Map A lane 1: green bits 1-5 in slots 0-4, blue bits 0-1 in slots 5-6.
// [RULE7] Map A lane 2: blue bits 2-5 in slots 0-3; slots 4-5 unused.
// [RULE8] Odd lane 2 slot 6 carries pixel valid; device takes validity there.
// [RULE9] Map A lane 3: red, green, blue bits 6-7 in slots 0-5; slot 6 reserved.
// [RULE10] Even port uses the same colour map; its valid slot is reserved.
// [RULE11] Map B moves colour bits 2-7 into map A's 0-5 slots; bits 0-1 to lane 3.
// [RULE12] Colour bit 0 is least significant, bit 7 most significant.
// [RULE13] Each active line holds 640 valid clocks, one odd and one even pixel each.
// [RULE14] Reserved slots are ignored by the device; sender drives them anyway.
// [RULE15] Odd and even words of one period leave together as one pixel pair.
package dpm_pkg;

  localparam int LANES = 4;                        // Data lanes per port
  localparam int SLOTS = 7;                        // Serial slots per lane per pixel
  localparam logic [2:0] SLOT_FIRST = 3'h0;        // Slot marked by frame rise
  localparam logic [2:0] SLOT_LAST  = 3'h6;        // Last slot of a pixel

  localparam int G_LO_SLOT = 6;                    // Lane 0: low green bit
  localparam int B_LO_SLOT = 5;                    // Lane 1: low blue pair base
  localparam int B_MID_W   = 4;                    // Lane 2: blue middle width
  localparam int VALID_SLOT = 6;                   // Lane 2: pixel valid (odd)
  localparam int R_HI_SLOT = 0;                    // Lane 3: red pair base
  localparam int G_HI_SLOT = 2;                    // Lane 3: green pair base
  localparam int B_HI_SLOT = 4;                    // Lane 3: blue pair base
  localparam int PAIR_W    = 2;                    // Bits per lane 3 colour pair

  localparam logic [9:0] LINE_ACTIVE = 10'h280;    // Valid clocks per line
  localparam logic [9:0] RUN_MAX     = 10'h3FF;    // Run counter ceiling

  typedef logic [SLOTS-1:0] dpm_lane_t;

  // One pixel as it arrives: four lanes of seven slots
  typedef struct packed {
    dpm_lane_t l3;
    dpm_lane_t l2;
    dpm_lane_t l1;
    dpm_lane_t l0;
  } dpm_word_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } dpm_pix_t;

  typedef struct packed {
    dpm_pix_t odd;
    dpm_pix_t even;
  } dpm_pair_t;

  typedef enum logic [1:0] {
    DPM_IDLE = 2'b00,
    DPM_ODD  = 2'b01,
    DPM_EVEN = 2'b10
  } dpm_state_t;

endpackage

// [core/dpm_sync2.sv]
// Two-stage level synchroniser, one per bit.
// Assumes each bit is a level or a toggle that changes slowly
// against clk; buses of related bits need their own handshake.
`timescale 1ns/1ps
module dpm_sync2
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,   // Destination clock
  input  wire logic [WIDTH-1:0] d,     // Asynchronous input
  output logic      [WIDTH-1:0] q      // Synchronised output
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q      <= meta_r;
  end

endmodule // dpm_sync2

// [core/dpm_port_deser.sv]
// Serial-to-parallel front end for one four-lane pixel port.
// Runs on the port's forwarded clock, one slot per edge; the
// sampled level of the clock pair rises at slot 0 of each pixel.
`timescale 1ns/1ps
module dpm_port_deser
(
  input  wire logic               link_clk,  // Forwarded port clock
  input  wire logic               sys_rst,   // Reset from the system domain
  input  wire logic [3:0]         lanes,     // Serial lane bits
  input  wire logic               frame_lvl, // Clock pair level, rises at slot 0
  output logic                    word_tgl,  // Flips once per assembled pixel
  output dpm_pkg::dpm_word_t      word_r     // Last assembled pixel
);

  logic                            rst_l;
  logic                            mark_q_r;
  logic                            rise;
  logic [2:0]                      slot_r;
  logic [2:0]                      cur_slot;
  dpm_pkg::dpm_lane_t              sh_r [dpm_pkg::LANES];
  logic [dpm_pkg::LANES*dpm_pkg::SLOTS-1:0] cat;

  // Reset must cross before it may steer this domain
  dpm_sync2 #(.WIDTH(1)) u_rst_sync
  (
    .clk (link_clk),
    .d   (sys_rst),
    .q   (rst_l)
  );

  // Frame rise realigns the slot count, so a slip heals in one pixel
  assign rise     = frame_lvl && !mark_q_r;
  assign cur_slot = rise ? dpm_pkg::SLOT_FIRST : slot_r;

  always_ff @(posedge link_clk)
  begin
    mark_q_r <= frame_lvl;
  end

  always_ff @(posedge link_clk)
  begin
    if (rst_l)
      slot_r <= dpm_pkg::SLOT_FIRST;
    else if (cur_slot == dpm_pkg::SLOT_LAST)
      slot_r <= dpm_pkg::SLOT_FIRST;
    else
      slot_r <= cur_slot + 3'h1;
  end

  // Slot 0 shifts in first and ends in bit 0 of each lane word
  for (genvar l = 0; l < dpm_pkg::LANES; l++)
  begin : g_lane
    always_ff @(posedge link_clk)
    begin
      sh_r[l] <= {lanes[l], sh_r[l][dpm_pkg::SLOTS-1:1]};
    end
    assign cat[l*dpm_pkg::SLOTS +: dpm_pkg::SLOTS] =
      {lanes[l], sh_r[l][dpm_pkg::SLOTS-1:1]};
  end

  // Word stays put for a whole pixel, long enough for the far side
  always_ff @(posedge link_clk)
  begin
    if (rst_l)
    begin
      word_tgl <= 1'b0;
      word_r   <= '0;
    end
    else if (cur_slot == dpm_pkg::SLOT_LAST)
    begin
      word_tgl <= !word_tgl;
      word_r   <= cat;
    end
  end

endmodule // dpm_port_deser

// [core/dpm_top.sv]
// Dual-port pixel input map: unpacks odd and even ports into pairs.
// Assumes each port's lanes are source-synchronous to its own clock,
// the strap pin is asynchronous, and sys_clk runs far faster than
// the pixel rate so both words are caught well inside a pixel.
`timescale 1ns/1ps
module dpm_top
(
  input  wire logic          sys_clk,          // System clock, 125 MHz
  input  wire logic          sys_rst,          // Synchronous reset, high
  input  wire logic          odd_port_clock,   // Odd port forwarded clock
  input  wire logic [3:0]    odd_port_pairs,   // Odd port serial lanes
  input  wire logic          odd_port_frame,   // Odd clock pair level
  input  wire logic          even_port_clock,  // Even port forwarded clock
  input  wire logic [3:0]    even_port_pairs,  // Even port serial lanes
  input  wire logic          even_port_frame,  // Even clock pair level
  input  wire logic          input_map_select, // Strap: high/open A, low B
  output dpm_pkg::dpm_pair_t pair_r,           // Decoded pixel pair
  output logic               pair_strobe,      // One cycle per new pair
  output logic               pixel_valid,      // Pair lies in active line
  output logic               map_mode_b,       // Map B in use
  output logic               skew_err,         // One port ran a word ahead
  output logic               line_len_err      // Active run was not 640
);

  logic                 odd_tgl;
  logic                 even_tgl;
  dpm_pkg::dpm_word_t   odd_word;
  dpm_pkg::dpm_word_t   even_word;
  logic                 sel_s;
  logic [1:0]           tgl_s;
  logic [1:0]           tgl_d_r;
  logic                 new_odd;
  logic                 new_even;
  dpm_pkg::dpm_pix_t    odd_pix;
  dpm_pkg::dpm_pix_t    even_pix;
  logic                 odd_pv;
  dpm_pkg::dpm_state_t  state_r;
  dpm_pkg::dpm_state_t  state_nxt;
  dpm_pkg::dpm_pix_t    held_r;
  logic                 held_pv_r;
  logic                 emit;
  logic                 skew;
  dpm_pkg::dpm_pix_t    emit_odd;
  dpm_pkg::dpm_pix_t    emit_even;
  logic                 emit_pv;
  logic [9:0]           run_r;
  logic                 in_line_r;

  // Colour unpack; map B swaps which end of the byte lane 3 supplies
  function automatic dpm_pkg::dpm_pix_t f_decode
  (
    input dpm_pkg::dpm_word_t w,
    input logic               mode_b
  );
    logic [5:0]        r6;
    logic [5:0]        g6;
    logic [5:0]        b6;
    logic [1:0]        r2;
    logic [1:0]        g2;
    logic [1:0]        b2;
    dpm_pkg::dpm_pix_t p;
    r6 = w.l0[dpm_pkg::G_LO_SLOT-1:0];
    g6 = {w.l1[dpm_pkg::B_LO_SLOT-1:0], w.l0[dpm_pkg::G_LO_SLOT]};
    b6 = {w.l2[dpm_pkg::B_MID_W-1:0], w.l1[dpm_pkg::B_LO_SLOT +: dpm_pkg::PAIR_W]};
    r2 = w.l3[dpm_pkg::R_HI_SLOT +: dpm_pkg::PAIR_W];
    g2 = w.l3[dpm_pkg::G_HI_SLOT +: dpm_pkg::PAIR_W];
    b2 = w.l3[dpm_pkg::B_HI_SLOT +: dpm_pkg::PAIR_W];
    if (mode_b)
    begin
      p.red   = {r6, r2};
      p.green = {g6, g2};
      p.blue  = {b6, b2};
    end
    else
    begin
      p.red   = {r2, r6};
      p.green = {g2, g6};
      p.blue  = {b2, b6};
    end
    return p;
  endfunction

  // [RULE3] odd port front end
  dpm_port_deser u_odd
  (
    .link_clk  (odd_port_clock),
    .sys_rst   (sys_rst),
    .lanes     (odd_port_pairs),
    .frame_lvl (odd_port_frame),
    .word_tgl  (odd_tgl),
    .word_r    (odd_word)
  );

  // [RULE4] even port front end
  dpm_port_deser u_even
  (
    .link_clk  (even_port_clock),
    .sys_rst   (sys_rst),
    .lanes     (even_port_pairs),
    .frame_lvl (even_port_frame),
    .word_tgl  (even_tgl),
    .word_r    (even_word)
  );

  // Strap is a slow pin; two flops are enough
  dpm_sync2 #(.WIDTH(1)) u_sel_sync
  (
    .clk (sys_clk),
    .d   (input_map_select),
    .q   (sel_s)
  );

  // Toggles cross here; the words they announce are already steady
  dpm_sync2 #(.WIDTH(2)) u_tgl_sync
  (
    .clk (sys_clk),
    .d   ({even_tgl, odd_tgl}),
    .q   (tgl_s)
  );

  assign new_odd  = tgl_s[0] ^ tgl_d_r[0];
  assign new_even = tgl_s[1] ^ tgl_d_r[1];

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      tgl_d_r <= 2'h0;
    else
      tgl_d_r <= tgl_s;
  end

  // [RULE1] map choice follows the strap
  // [RULE2] an open strap reads high through the pull-up
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      map_mode_b <= 1'b0;
    else
      map_mode_b <= !sel_s;
  end

  // [RULE12] bit 0 lands at the byte's least significant end
  // [RULE14] reserved slots never reach the decode
  assign odd_pix  = f_decode(odd_word, map_mode_b);
  assign even_pix = f_decode(even_word, map_mode_b);

  // [RULE8] validity comes from the odd port only
  assign odd_pv = odd_word.l2[dpm_pkg::VALID_SLOT];

  // [RULE15] pair odd and even words of one pixel period
  always_comb
  begin
    state_nxt = state_r;
    emit      = 1'b0;
    skew      = 1'b0;
    emit_odd  = odd_pix;
    emit_even = even_pix;
    emit_pv   = odd_pv;
    unique case (state_r)
      dpm_pkg::DPM_IDLE:
      begin
        if (new_odd && new_even)
          emit = 1'b1;
        else if (new_odd)
          state_nxt = dpm_pkg::DPM_ODD;
        else if (new_even)
          state_nxt = dpm_pkg::DPM_EVEN;
      end
      dpm_pkg::DPM_ODD:
      begin
        if (new_even)
        begin
          emit      = 1'b1;
          emit_odd  = held_r;
          emit_pv   = held_pv_r;
          state_nxt = new_odd ? dpm_pkg::DPM_ODD : dpm_pkg::DPM_IDLE;
        end
        else if (new_odd)
          skew = 1'b1;
      end
      dpm_pkg::DPM_EVEN:
      begin
        if (new_odd)
        begin
          emit      = 1'b1;
          emit_even = held_r;
          state_nxt = new_even ? dpm_pkg::DPM_EVEN : dpm_pkg::DPM_IDLE;
        end
        else if (new_even)
          skew = 1'b1;
      end
      default:
        state_nxt = dpm_pkg::DPM_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_r <= dpm_pkg::DPM_IDLE;
    else
      state_r <= state_nxt;
  end

  // Keep the unmatched half; a newer word from the same port replaces a stale one
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      held_r    <= '0;
      held_pv_r <= 1'b0;
    end
    else if (state_nxt == dpm_pkg::DPM_ODD && new_odd)
    begin
      held_r    <= odd_pix;
      held_pv_r <= odd_pv;
    end
    else if (state_nxt == dpm_pkg::DPM_EVEN && new_even)
      held_r <= even_pix;
  end

  // Output stage: data held until the next pair
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pair_r      <= '0;
      pixel_valid <= 1'b0;
      pair_strobe <= 1'b0;
      skew_err    <= 1'b0;
    end
    else
    begin
      pair_strobe <= emit;
      skew_err    <= skew;
      if (emit)
      begin
        pair_r.odd  <= emit_odd;
        pair_r.even <= emit_even;
        pixel_valid <= emit_pv;
      end
    end
  end

  // [RULE13] count valid pairs per line, judged when validity falls
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      run_r        <= '0;
      in_line_r    <= 1'b0;
      line_len_err <= 1'b0;
    end
    else
    begin
      line_len_err <= 1'b0;
      if (emit && emit_pv)
      begin
        in_line_r <= 1'b1;
        if (run_r != dpm_pkg::RUN_MAX)
          run_r <= run_r + 10'h001;
      end
      else if (emit && in_line_r)
      begin
        in_line_r    <= 1'b0;
        run_r        <= '0;
        line_len_err <= (run_r != dpm_pkg::LINE_ACTIVE);
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_map_low_b: assert property (!sel_s |=> map_mode_b) // [RULE1]
    else $error("low strap did not select map B");

  a_map_open_a: assert property (sel_s |=> !map_mode_b) // [RULE2]
    else $error("high strap did not select map A");

  a_odd_hold: assert property ( // [RULE3]
    state_r == dpm_pkg::DPM_IDLE && new_odd && !new_even
    |=> state_r == dpm_pkg::DPM_ODD && !pair_strobe)
    else $error("lone odd word was not held");

  a_even_hold: assert property ( // [RULE4]
    state_r == dpm_pkg::DPM_IDLE && new_even && !new_odd
    |=> state_r == dpm_pkg::DPM_EVEN && !pair_strobe)
    else $error("lone even word was not held");

  a_valid_odd: assert property ( // [RULE8]
    state_r == dpm_pkg::DPM_IDLE && new_odd && new_even
    |=> pair_strobe && pixel_valid == $past(odd_pv))
    else $error("pixel valid not taken from odd lane 2");

  a_bit_order_a: assert property ( // [RULE12]
    state_r == dpm_pkg::DPM_IDLE && new_odd && new_even && !map_mode_b
    |=> pair_r.odd.red == {$past(odd_word.l3[1:0]), $past(odd_word.l0[5:0])})
    else $error("map A red byte misordered");

  a_bit_order_b: assert property ( // [RULE12]
    state_r == dpm_pkg::DPM_IDLE && new_odd && new_even && map_mode_b
    |=> pair_r.even.blue == {$past(even_word.l2[3:0]),
                             $past(even_word.l1[6:5]), $past(even_word.l3[5:4])})
    else $error("map B blue byte misordered");

  a_pair_late: assert property ( // [RULE15]
    state_r == dpm_pkg::DPM_ODD && new_even
    |=> pair_strobe && pair_r.odd == $past(held_r))
    else $error("held odd word not paired with even");

  a_pair_single: assert property (pair_strobe |=> !pair_strobe) // [RULE15]
    else $error("pair strobe longer than one cycle");

  a_line_short: assert property ( // [RULE13]
    emit && !emit_pv && in_line_r && run_r != dpm_pkg::LINE_ACTIVE
    |=> line_len_err ##1 !line_len_err)
    else $error("wrong line length not flagged");

  a_line_ok: assert property ( // [RULE13]
    emit && !emit_pv && in_line_r && run_r == dpm_pkg::LINE_ACTIVE
    |=> !line_len_err && run_r == 10'h000)
    else $error("correct line flagged or run not cleared");

endmodule // dpm_top

// [verif/dpm_tx_model.sv]
// Behavioural serialiser for one four-lane pixel port.
// Assumes the bench calls its tasks; the clock stands still between calls.
`timescale 1ns/1ps
module dpm_tx_model
#(
  parameter bit IS_ODD = 1'b1
)
(
  output logic       link_clk, // Forwarded port clock
  output logic [3:0] lanes,    // Serial lane bits
  output logic       frame     // Clock pair level
);
  dpm_pkg::dpm_word_t w;

  // Idle levels at time zero
  initial
  begin
    link_clk = 1'b0;
    lanes    = 4'h0;
    frame    = 1'b0;
  end

  // Free clock pulses with frame low, around reset only; the link
  // side needs its own edges to see reset rise and fall
  task automatic idle(input int n);
    repeat (n)
    begin
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
    end
  endtask

  // Returns {lane 3 pair, six-bit field}
  function automatic logic [7:0] fld(input logic [7:0] c, input logic mb);
    return mb ? {c[1:0], c[7:2]} : c;
  endfunction

  task automatic send(input dpm_pkg::dpm_pix_t p, input logic de, input logic mb);
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    r = fld(p.red, mb);
    g = fld(p.green, mb);
    b = fld(p.blue, mb);
    w.l0 = {g[0], r[5:0]};
    w.l1 = {b[1:0], g[5:1]};
    // Valid on odd only; reserved slots driven high
    w.l2 = {IS_ODD ? de : 1'b1, 2'b11, b[5:2]};
    w.l3 = {1'b1, b[7:6], g[7:6], r[7:6]};
    // Slot k of every lane on edge k, frame high first
    for (int k = 0; k < 7; k++)
    begin
      lanes = {w.l3[k], w.l2[k], w.l1[k], w.l0[k]};
      frame = (k < 4);
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
    end
    lanes = ~lanes; // Released lanes must not keep the last value
  endtask
endmodule // dpm_tx_model

// [verif/dpm_top_test.sv]
// Self-checking bench for the dual-port pixel input map.
// Both ports are fed by serialiser models; the strap is driven directly.
`timescale 1ns/1ps
module dpm_top_test;
  logic               sys_clk;
  logic               sys_rst;
  logic               strap;
  logic               oclk;
  logic               eclk;
  logic               ofr;
  logic               efr;
  logic [3:0]         olanes;
  logic [3:0]         elanes;
  dpm_pkg::dpm_pair_t pair_r;
  dpm_pkg::dpm_pair_t got;
  logic               got_valid;
  logic               pair_strobe;
  logic               pixel_valid;
  logic               map_mode_b;
  logic               skew_err;
  logic               line_len_err;
  int                 mismatches = 0;
  int                 checks = 0;
  int                 n_pairs = 0;
  int                 n_len = 0;
  int                 n_skew = 0;
  int                 cycles = 0;

  dpm_top dpm_top_inst (
    .sys_clk          (sys_clk),
    .sys_rst          (sys_rst),
    .odd_port_clock   (oclk),
    .odd_port_pairs   (olanes),
    .odd_port_frame   (ofr),
    .even_port_clock  (eclk),
    .even_port_pairs  (elanes),
    .even_port_frame  (efr),
    .input_map_select (strap),
    .pair_r           (pair_r),
    .pair_strobe      (pair_strobe),
    .pixel_valid      (pixel_valid),
    .map_mode_b       (map_mode_b),
    .skew_err         (skew_err),
    .line_len_err     (line_len_err)
  );
  dpm_tx_model #(.IS_ODD(1'b1)) dpm_tx_model_inst (
    .link_clk (oclk),
    .lanes    (olanes),
    .frame    (ofr)
  );
  dpm_tx_model #(.IS_ODD(1'b0)) dpm_tx_model_even_inst (
    .link_clk (eclk),
    .lanes    (elanes),
    .frame    (efr)
  );

  // 125 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Record pairs and error pulses; the cycle ceiling cuts a hang short
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (pair_strobe === 1'b1)
    begin
      n_pairs   <= n_pairs + 1;
      got       <= pair_r;
      got_valid <= pixel_valid;
    end
    if (line_len_err === 1'b1)
      n_len <= n_len + 1;
    if (skew_err === 1'b1)
      n_skew <= n_skew + 1;
    if (cycles == 95000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input logic [47:0] exp, input logic [47:0] act);
    checks++;
    if (act !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Both ports in step; the even valid argument is not carried
  task automatic send_pair(input logic [47:0] px, input logic de);
    fork
      dpm_tx_model_inst.send(px[47:24], de, ~strap);
      dpm_tx_model_even_inst.send(px[23:0], 1'b0, ~strap);
    join
  endtask

  task automatic wait_pairs(input int n);
    for (int i = 0; i < 40 && n_pairs < n; i++)
      @(negedge sys_clk);
  endtask

  // A valid pair then an invalid one; the one-pair run is flagged short
  task automatic pair_and_close(input logic [47:0] px);
    int base;
    int len0;
    base = n_pairs;
    len0 = n_len;
    send_pair(px, 1'b1);
    wait_pairs(base + 1);
    check(px, got);
    check(48'h1, 48'(got_valid));
    send_pair(~px, 1'b0);
    wait_pairs(base + 2);
    repeat (3) @(negedge sys_clk);
    check(~px, got);
    check(48'h0, 48'(got_valid));
    check(48'(base + 2), 48'(n_pairs));
    check(48'(len0 + 1), 48'(n_len));
  endtask

  task automatic t_map_a();
    check(48'h0, 48'(map_mode_b));
    pair_and_close(48'h81C35A_3E7F01);
  endtask

  task automatic t_map_b();
    strap = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(48'h1, 48'(map_mode_b));
    pair_and_close(48'h17E4A9_C20B6D);
    strap = 1'b1;
    repeat (4) @(negedge sys_clk);
    check(48'h0, 48'(map_mode_b));
  endtask

  // A full active line of 640 valid pairs raises no length error
  task automatic t_line();
    int base;
    int len0;
    base = n_pairs;
    len0 = n_len;
    repeat (640) send_pair(48'h102030_405060, 1'b1);
    send_pair(48'h0F0F0F_F0F0F0, 1'b0);
    wait_pairs(base + 641);
    repeat (3) @(negedge sys_clk);
    check(48'(base + 641), 48'(n_pairs));
    check(48'(len0), 48'(n_len));
    check(48'h0, 48'(n_skew));
  endtask

  // One port runs ahead: odd twice then even, later even then odd
  task automatic t_skew();
    int base;
    int sk0;
    int len0;
    base = n_pairs;
    sk0  = n_skew;
    len0 = n_len;
    dpm_tx_model_inst.send(24'h112233, 1'b0, ~strap);
    dpm_tx_model_inst.send(24'h445566, 1'b0, ~strap);
    repeat (4) @(negedge sys_clk);
    check(48'(base), 48'(n_pairs));
    check(48'(sk0 + 1), 48'(n_skew));
    dpm_tx_model_even_inst.send(24'h778899, 1'b0, ~strap);
    wait_pairs(base + 1);
    repeat (3) @(negedge sys_clk);
    check(48'h445566_778899, got);
    dpm_tx_model_even_inst.send(24'hAABBCC, 1'b0, ~strap);
    dpm_tx_model_inst.send(24'hDDEEFF, 1'b0, ~strap);
    wait_pairs(base + 2);
    repeat (3) @(negedge sys_clk);
    check(48'hDDEEFF_AABBCC, got);
    check(48'(base + 2), 48'(n_pairs));
    check(48'(sk0 + 1), 48'(n_skew));
    check(48'(len0), 48'(n_len));
  endtask

  // Reset spans several link clock edges, as the link logic needs them
  initial
  begin
    sys_rst = 1'b1;
    strap   = 1'b1;
    fork
      dpm_tx_model_inst.idle(5);
      dpm_tx_model_even_inst.idle(5);
    join
    @(negedge sys_clk);
    check(48'h0, 48'({pair_strobe, pixel_valid, map_mode_b, skew_err, line_len_err}));
    sys_rst = 1'b0;
    // The link side sees the release only through its own clock edges
    fork
      dpm_tx_model_inst.idle(3);
      dpm_tx_model_even_inst.idle(3);
    join
    repeat (4) @(negedge sys_clk);
    t_map_a();
    t_map_b();
    t_line();
    t_skew();
    print_verdict();
  end
endmodule // dpm_top_test
